// ===== hw/sgi_pkg.sv
// Purpose: shared constants and types for the memory start-up and mode register block
// Assumes: 25 MHz core clock; command decode happens upstream on the same clock
// Notes:   times are held in ns and turned into cycle counts here
package sgi_pkg;
   // ----------------------------------------
   // clock and timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   // latest moment for termination enable: longest time, rounds down
   localparam int INIT2_NS = 20000;
   localparam int INIT2_CYC = INIT2_NS / CLK_PERIOD_NS;
   // least times round up
   localparam int CSP_PRE_NS = 100;
   localparam int CSP_PRE_CYC = (CSP_PRE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CSP_POST_NS = 100;
   localparam int CSP_POST_CYC = (CSP_POST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MOD_NS = 60;
   localparam int MOD_CYC = (MOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // stable write clock cycles before automatic training entry
   localparam int INIT3_CYC_DEF = 2048;
   // ----------------------------------------
   // info read latency, in quad_cmd_clock_cycles
   // ----------------------------------------
   localparam logic [4:0] IRD_LAT_MIN = 5'h0A;
   localparam logic [4:0] IRD_LAT_MAX = 5'h12;
   localparam logic [4:0] IRD_LAT_DEF = 5'h0E;
   // ----------------------------------------
   // mode registers
   // ----------------------------------------
   localparam int NUM_MR = 64;
   localparam int MR_W = 12;
   localparam int FD_NUM = 6;
   localparam logic [5:0] FD_LO = 6'h0A;
   localparam logic [5:0] FD_HI = 6'h0F;
   localparam logic [5:0] MR_WCLK = 6'h0C;
   localparam int POSTPONE_BIT = 11;
   localparam logic [MR_W-1:0] MR_RST = 12'h000;
   // latched configuration bits on the low command-address inputs
   localparam int CFG_CA_TERM_BIT = 1;
   localparam int CFG_WCK_TERM_BIT = 2;
   // ----------------------------------------
   // register map (byte addresses, low 12 bits decoded)
   // ----------------------------------------
   localparam logic [11:0] OFF_STATUS = 12'h000;
   localparam logic [11:0] OFF_ERR = 12'h004;
   localparam logic [11:0] OFF_IRD_LAT = 12'h008;
   localparam logic [11:0] OFF_CFG = 12'h00C;
   localparam logic [3:0] MR_WIN_PAGE = 4'h1;
   // error flag positions
   localparam int ERR_W = 6;
   localparam int ERR_ACTIVE_BANK = 0;
   localparam int ERR_MRS_BUSY = 1;
   localparam int ERR_WCLK_REG = 2;
   localparam int ERR_FLAG_PEND = 3;
   localparam int ERR_CSP_EARLY = 4;
   localparam int ERR_WCK_LOST = 5;
   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [3:0] {
      CMD_NONE, CMD_ROW_NOP_LONG, CMD_COLUMN_NOP_LONG, CMD_COMMAND_START_POINT,
      CMD_CA_TRAINING_EXIT, CMD_MODE_SET, CMD_INFO_READ, CMD_SLEEP_ENTRY,
      CMD_SLEEP_EXIT, CMD_OTHER
   } sgi_cmd_e_t;
   typedef struct packed {
      logic valid;
      sgi_cmd_e_t code;
      logic [5:0] addr;
      logic [MR_W-1:0] data;
   } sgi_cmd_t;
   typedef enum logic [3:0] {
      ST_RESET, ST_CAL, ST_WCK_WAIT, ST_CA_TRAIN, ST_CSP_PRE, ST_CSP_WAIT,
      ST_CSP_POST, ST_READY, ST_SLEEP, ST_UNDEF
   } sgi_state_t;
endpackage : sgi_pkg

// ===== hw/sgi_init_mr_ctrl.sv
// Purpose: start-up sequencing and mode register store of the memory device
// Assumes: commands arrive decoded on clk; pins pass two flip-flops first
// Notes:   registers reached over an AHB-Lite slave with zero wait states
//
// What this block does
// R1: host holds config levels after reset release
// R2: NOPs held high; calibration runs without clock
// R3: termination enabled before second init delay
// R4: host gives stable write clock long enough
// R5: write clock stop outside sleep is fatal
// R6: automatic command-address training after third delay
// R7: start point only after pre time, then post
// R8: info read latency default between 10 and 18
// R9: host programs all mode registers before training; mode set is taken only in ST_READY, after training
// R10: reset pulse restarts from configuration setup
// R11: 64 mode registers, top sixteen vendor
// R12: values kept until rewrite or reset
// R13: mode set only when idle, wait delay; a mode set inside the delay is still taken and sets ERR_MRS_BUSY
// R14: few registers writable with bank active
// R15: reserved bits zero, unknown options ignored
// R16: postponed frequency registers applied at sleep entry
// R17: flag set: frequency registers apply directly
// R18: flag set only with nothing pending; setting it with writes pending is still taken and sets ERR_FLAG_PEND
// R19: clock frequency register only with flag clear
// R20: avoid other frequency writes with flag set
// R21: config levels set up before release
// R22: power-up reset held for first delay
// R23: chip reset discards staged register writes
//
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module sgi_init_mr_ctrl #(
   parameter int INIT3_CYCLES = sgi_pkg::INIT3_CYC_DEF
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic reset_n_pin,
   input wire logic [4:0] ca_cfg_pin,
   input wire logic wclk_running_pin,
   input wire sgi_pkg::sgi_cmd_t cmd,
   input wire logic bank_active,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic wck_term_en,
   output logic ca_term_en,
   output logic ca_training,
   output logic init_done,
   output logic postpone_flag,
   output logic [4:0] ird_latency
);
   import sgi_pkg::*;

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [6:0] sync1;
   logic [6:0] sync2;
   logic rst_pin_s;
   logic [4:0] ca_cfg_s;
   logic wck_s;
   always_ff @(posedge clk) begin
      sync1 <= {wclk_running_pin, ca_cfg_pin, reset_n_pin};
      sync2 <= sync1;
   end
   assign rst_pin_s = sync2[0];
   assign ca_cfg_s = sync2[5:1];
   assign wck_s = sync2[6];

   // pin reset acts like the chip reset for sequencer, mode register and latency state; error flags and latched config see chip reset only
   logic dev_rst;
   assign dev_rst = reset || !rst_pin_s; // R10 R22

   // ----------------------------------------
   // start-up sequencer
   // ----------------------------------------
   sgi_state_t state;
   logic [15:0] tmr;
   logic [4:0] cfg;
   logic wck_lost;
   logic cmd_csp;
   logic cmd_ca_training_exit;
   logic sleep_take;
   assign cmd_csp = cmd.valid && cmd.code == CMD_COMMAND_START_POINT;
   assign cmd_ca_training_exit = cmd.valid && cmd.code == CMD_CA_TRAINING_EXIT;
   assign sleep_take = cmd.valid && cmd.code == CMD_SLEEP_ENTRY && state == ST_READY;
   // once the write clock is required only sleep may see it stopped
   assign wck_lost = !wck_s && (state inside {ST_CA_TRAIN, ST_CSP_PRE, ST_CSP_WAIT,
                                               ST_CSP_POST, ST_READY}); // R5

   always_ff @(posedge clk) begin
      if (dev_rst) begin
         state <= ST_RESET;
         tmr <= 16'h0000;
      end else if (wck_lost) begin
         state <= ST_UNDEF; // R5
      end else begin
         case (state)
            ST_RESET: begin
               state <= ST_CAL;
               tmr <= 16'h0000;
            end
            // impedance calibration on the core clock only
            ST_CAL: begin // R2
               if (tmr == 16'(INIT2_CYC - 1)) begin
                  state <= ST_WCK_WAIT;
                  tmr <= 16'h0000;
               end else begin
                  tmr <= tmr + 16'h0001;
               end
            end
            // any gap in the write clock restarts the stable count
            ST_WCK_WAIT: begin // R4
               if (!wck_s) begin
                  tmr <= 16'h0000;
               end else if (tmr == 16'(INIT3_CYCLES - 1)) begin
                  state <= ST_CA_TRAIN; // R6
                  tmr <= 16'h0000;
               end else begin
                  tmr <= tmr + 16'h0001;
               end
            end
            ST_CA_TRAIN: begin
               if (cmd_ca_training_exit) begin
                  state <= ST_CSP_PRE;
                  tmr <= 16'h0000;
               end
            end
            ST_CSP_PRE: begin // R7
               if (tmr == 16'(CSP_PRE_CYC - 1)) begin
                  state <= ST_CSP_WAIT;
                  tmr <= 16'h0000;
               end else begin
                  tmr <= tmr + 16'h0001;
               end
            end
            ST_CSP_WAIT: begin
               if (cmd_csp) begin
                  state <= ST_CSP_POST;
                  tmr <= 16'h0000;
               end
            end
            ST_CSP_POST: begin // R7
               if (tmr == 16'(CSP_POST_CYC - 1)) begin
                  state <= ST_READY;
               end else begin
                  tmr <= tmr + 16'h0001;
               end
            end
            ST_READY: begin
               if (sleep_take) begin
                  state <= ST_SLEEP;
               end
            end
            ST_SLEEP: begin
               if (cmd.valid && cmd.code == CMD_SLEEP_EXIT) begin
                  state <= ST_READY;
               end
            end
            default: begin
               state <= ST_UNDEF;
            end
         endcase
      end
   end

   // configuration caught on the first cycle the released pin is seen
   always_ff @(posedge clk) begin
      if (reset) begin
         cfg <= 5'h00;
      end else if (state == ST_RESET && rst_pin_s) begin
         cfg <= ca_cfg_s; // R1 R21
      end
   end

   // termination follows the latched straps at the end of calibration
   always_ff @(posedge clk) begin
      if (dev_rst) begin
         wck_term_en <= 1'b0;
         ca_term_en <= 1'b0;
      end else if (state == ST_CAL && tmr == 16'(INIT2_CYC - 1)) begin
         wck_term_en <= cfg[CFG_WCK_TERM_BIT]; // R3
         ca_term_en <= cfg[CFG_CA_TERM_BIT]; // R3
      end
   end

   always_ff @(posedge clk) begin
      if (dev_rst) begin
         ca_training <= 1'b0;
         init_done <= 1'b0;
      end else begin
         ca_training <= (state == ST_CA_TRAIN);
         init_done <= (state == ST_READY) || (state == ST_SLEEP);
      end
   end

   // ----------------------------------------
   // mode registers
   // ----------------------------------------
   logic [MR_W-1:0] mr_app [NUM_MR]; // R11
   logic [MR_W-1:0] fd_stage [FD_NUM];
   logic [FD_NUM-1:0] fd_pend;
   logic [2:0] mod_cnt;
   logic mrs_take;
   logic is_fd;
   logic ok_active;
   logic blk_active;
   logic blk_wclk;
   logic accept;
   logic stage;
   logic direct;
   logic [2:0] fd_idx;
   assign mrs_take = cmd.valid && cmd.code == CMD_MODE_SET && state == ST_READY;
   assign is_fd = cmd.addr >= FD_LO && cmd.addr <= FD_HI;
   assign fd_idx = 3'(cmd.addr - FD_LO);
   assign ok_active = (cmd.addr >= 6'h05 && cmd.addr <= 6'h07)
                   || (cmd.addr >= 6'h10 && cmd.addr <= 6'h15)
                   || (cmd.addr >= 6'h17 && cmd.addr <= 6'h1A);
   assign blk_active = bank_active && !ok_active; // R14
   // the clock frequency register only moves through sleep
   assign blk_wclk = cmd.addr == MR_WCLK && postpone_flag; // R19
   assign accept = mrs_take && !blk_active && !blk_wclk;
   assign stage = accept && is_fd && !postpone_flag; // R16
   assign direct = accept && !stage; // R17 R20
   assign postpone_flag = mr_app[0][POSTPONE_BIT];

   // the whole word is stored; no optional field is implemented, so set
   // optional or reserved bits steer nothing here
   always_ff @(posedge clk) begin
      if (dev_rst) begin
         for (int i = 0; i < NUM_MR; i++) begin
            mr_app[i] <= MR_RST; // R12
         end
      end else if (direct) begin
         mr_app[cmd.addr] <= cmd.data; // R12 R15
      end else if (sleep_take) begin
         for (int i = 0; i < FD_NUM; i++) begin
            if (fd_pend[i]) begin
               mr_app[FD_LO + 6'(i)] <= fd_stage[i]; // R16
            end
         end
      end
   end

   // last write wins; rewriting the active value cancels the pending one
   genvar g;
   generate
      for (g = 0; g < FD_NUM; g++) begin : g_fd
         always_ff @(posedge clk) begin
            if (dev_rst) begin
               fd_stage[g] <= MR_RST;
               fd_pend[g] <= 1'b0; // R23
            end else if (stage && fd_idx == 3'(g)) begin
               fd_stage[g] <= cmd.data; // R16
               fd_pend[g] <= cmd.data != mr_app[FD_LO + 6'(g)]; // R18
            end else if (sleep_take) begin
               fd_pend[g] <= 1'b0; // R16
            end
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (dev_rst) begin
         mod_cnt <= 3'h0;
      end else if (accept) begin
         mod_cnt <= 3'(MOD_CYC); // R13
      end else if (mod_cnt != 3'h0) begin
         mod_cnt <= mod_cnt - 3'h1;
      end
   end

   // ----------------------------------------
   // AHB-Lite slave
   // ----------------------------------------
   logic ap;
   logic wr_pend;
   logic [11:0] wr_addr;
   logic [ERR_W-1:0] err;
   logic [ERR_W-1:0] err_set;
   logic [ERR_W-1:0] err_clr;
   logic [31:0] rd_val;
   assign ap = hsel && htrans[1] && hready;

   always_comb begin
      err_set = '0;
      err_set[ERR_ACTIVE_BANK] = mrs_take && blk_active; // R14
      err_set[ERR_MRS_BUSY] = mrs_take && mod_cnt != 3'h0; // R13
      err_set[ERR_WCLK_REG] = mrs_take && blk_wclk; // R19
      err_set[ERR_FLAG_PEND] = direct && cmd.addr == 6'h00
                             && cmd.data[POSTPONE_BIT] && !postpone_flag
                             && fd_pend != '0; // R18
      err_set[ERR_CSP_EARLY] = cmd_csp && state == ST_CSP_PRE; // R7
      err_set[ERR_WCK_LOST] = wck_lost; // R5
   end
   assign err_clr = (wr_pend && wr_addr == OFF_ERR) ? hwdata[ERR_W-1:0] : '0;

   always_ff @(posedge clk) begin
      if (reset) begin
         wr_pend <= 1'b0;
         wr_addr <= 12'h000;
      end else begin
         wr_pend <= ap && hwrite;
         wr_addr <= haddr[11:0];
      end
   end

   // set wins over the write-one clear in the same cycle
   always_ff @(posedge clk) begin
      if (reset) begin
         err <= '0;
      end else begin
         err <= (err & ~err_clr) | err_set;
      end
   end

   // out-of-range latency values are clamped into the legal window
   always_ff @(posedge clk) begin
      if (dev_rst) begin
         ird_latency <= IRD_LAT_DEF; // R8
      end else if (wr_pend && wr_addr == OFF_IRD_LAT) begin
         if (hwdata[4:0] < IRD_LAT_MIN) begin
            ird_latency <= IRD_LAT_MIN; // R8
         end else if (hwdata[4:0] > IRD_LAT_MAX) begin
            ird_latency <= IRD_LAT_MAX; // R8
         end else begin
            ird_latency <= hwdata[4:0];
         end
      end
   end

   always_comb begin
      rd_val = 32'h0000_0000;
      if (haddr[11:0] == OFF_STATUS) begin
         rd_val = {16'h0000, 2'b00, mod_cnt != 3'h0, fd_pend, postpone_flag,
                   ca_term_en, wck_term_en, 4'(state)};
      end else if (haddr[11:0] == OFF_ERR) begin
         rd_val = {26'h0, err};
      end else if (haddr[11:0] == OFF_IRD_LAT) begin
         rd_val = {27'h0, ird_latency};
      end else if (haddr[11:0] == OFF_CFG) begin
         rd_val = {27'h0, cfg};
      end else if (haddr[11:8] == MR_WIN_PAGE) begin
         rd_val = {20'h0, mr_app[haddr[7:2]]}; // R11
      end
   end

   // read data is sampled in the address phase so it can leave a flop
   always_ff @(posedge clk) begin
      if (reset) begin
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (ap && !hwrite) begin
            hrdata <= rd_val;
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   localparam int CHK_INIT2 = INIT2_CYC + 1;
   default clocking chk_cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_cal_start;
      $rose(state == ST_CAL);
   endsequence
   sequence s_stage_write;
      stage ##1 (fd_pend != '0);
   endsequence

   chk_term_by_delay: assert property (s_cal_start |-> ##[1:CHK_INIT2] // R3
      (wck_term_en == cfg[CFG_WCK_TERM_BIT] && ca_term_en == cfg[CFG_CA_TERM_BIT]))
      else $error("termination not enabled in time");
   chk_auto_training: assert property ((state == ST_WCK_WAIT && wck_s && !dev_rst // R6
      && tmr == 16'(INIT3_CYCLES - 1)) |=> ##1 ca_training)
      else $error("training not entered after write clock wait");
   chk_ird_window: assert property (ird_latency >= IRD_LAT_MIN // R8
      && ird_latency <= IRD_LAT_MAX)
      else $error("info read latency out of range");
   chk_stage_holds: assert property ((stage && cmd.data != mr_app[cmd.addr] && !dev_rst) // R16
      |-> s_stage_write ##0 $stable(postpone_flag))
      else $error("postponed write not held pending");
   chk_sleep_applies: assert property ((sleep_take && !dev_rst) |=> // R16
      (fd_pend == '0 && state == ST_SLEEP))
      else $error("pending writes not applied at sleep entry");
   chk_direct_apply: assert property ((direct && !dev_rst) |=> // R17
      (mr_app[$past(cmd.addr)] == $past(cmd.data) && mod_cnt == 3'(MOD_CYC)))
      else $error("direct write not applied");
   chk_reset_discard: assert property (!rst_pin_s |=> // R23
      (fd_pend == '0 && state == ST_RESET && !postpone_flag))
      else $error("staged writes survived reset");
   chk_active_block: assert property ((mrs_take && blk_active && !dev_rst) |=> // R14
      (mr_app[$past(cmd.addr)] == $past(mr_app[cmd.addr]) && err[ERR_ACTIVE_BANK]))
      else $error("blocked write changed a register");
   chk_wck_fatal: assert property ((wck_lost && !dev_rst) |=> // R5
      (state == ST_UNDEF)[*2])
      else $error("write clock loss not trapped");
   chk_csp_order: assert property ((cmd_ca_training_exit && state == ST_CA_TRAIN && !dev_rst) |=> // R7
      (state == ST_CSP_PRE)[*3])
      else $error("start point pre time not kept");
endmodule : sgi_init_mr_ctrl
`default_nettype wire

// ===== sim/sgi_host_model.sv
// Purpose: host controller model: reset pin, config levels, write clock and command stream
// Assumes: one command per two cycles, signals changed just after a rising edge
// Notes:   idle commands carry inverted address and data so stale ones never look fresh
`timescale 1ns/1ps
`default_nettype none
module sgi_host_model #(
   parameter int HOLD_CYC = 4
) (
   input wire logic clk,
   output logic reset_n_pin,
   output logic [4:0] ca_cfg_pin,
   output logic wclk_running_pin,
   output sgi_pkg::sgi_cmd_t cmd
);
   import sgi_pkg::*;
   initial begin
      reset_n_pin = 1'b0;
      ca_cfg_pin = 5'h1F;
      wclk_running_pin = 1'b0;
      cmd = '0;
   end
   // every command is followed by an idle cycle so two sends never collide in one step
   task automatic send(input sgi_cmd_e_t code, input logic [5:0] a, input logic [MR_W-1:0] d);
      cmd <= '{1'b1, code, a, d};
      @(posedge clk);
      cmd <= '{1'b0, CMD_NONE, ~a, ~d};
      @(posedge clk);
   endtask : send
   task automatic nops(input int n);
      for (int i = 0; i < n; i++) begin
         send(i % 2 ? CMD_COLUMN_NOP_LONG : CMD_ROW_NOP_LONG, 6'h3F, 12'hFFF);
      end
   endtask : nops
   task automatic set_wclk(input logic on);
      wclk_running_pin <= on;
   endtask : set_wclk
   task automatic power_up(input logic [4:0] cfg, input int low_cyc);
      reset_n_pin <= 1'b0;
      wclk_running_pin <= 1'b0;
      repeat (low_cyc) @(posedge clk);
      ca_cfg_pin <= cfg;
      repeat (4) @(posedge clk);
      reset_n_pin <= 1'b1;
      repeat (HOLD_CYC) @(posedge clk);
      ca_cfg_pin <= 5'h1F;
      wclk_running_pin <= 1'b1;
   endtask : power_up
endmodule : sgi_host_model
`default_nettype wire

// ===== sim/tb_sgram_init_and_mode_reg_control.sv
// Purpose: self-checking bench for start-up sequencing and mode register store
// Assumes: zero wait state register bus; short automatic-training wait of 16 cycles
// Notes:   mode registers are mirrored in int arrays, staged and applied copies apart
`timescale 1ns/1ps
`default_nettype none
module tb_sgram_init_and_mode_reg_control;
   import sgi_pkg::*;
   localparam int TIMEOUT_CYC = 20000;
   logic clk, reset, hsel, hwrite, bank_active, reset_n_pin, wclk_running_pin;
   logic hreadyout, hresp, wck_term_en, ca_term_en, ca_training, init_done, postpone_flag;
   logic [4:0] ca_cfg_pin, ird_latency, cfg_exp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   sgi_cmd_t cmd;
   int errors, total_checks, cycles, seed;
   int mr_app[NUM_MR];
   int mr_stg[NUM_MR];
   int addrs[5] = '{1, 9, 47, 48, 63};
   sgi_host_model u_host (.clk(clk), .reset_n_pin(reset_n_pin), .ca_cfg_pin(ca_cfg_pin),
      .wclk_running_pin(wclk_running_pin), .cmd(cmd));
   sgi_init_mr_ctrl #(.INIT3_CYCLES(16)) u_dut (.clk(clk), .reset(reset),
      .reset_n_pin(reset_n_pin), .ca_cfg_pin(ca_cfg_pin), .wclk_running_pin(wclk_running_pin),
      .cmd(cmd), .bank_active(bank_active), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .wck_term_en(wck_term_en), .ca_term_en(ca_term_en),
      .ca_training(ca_training), .init_done(init_done), .postpone_flag(postpone_flag),
      .ird_latency(ird_latency));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // ----------------------------------------
   // reporting and bus tasks
   // ----------------------------------------
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : print_verdict
   always @(posedge clk) begin
      cycles++;
      if (cycles >= TIMEOUT_CYC) begin
         errors++;
         $display("CHECK FAILED run time expected below %0d seen %0d", TIMEOUT_CYC, cycles);
         print_verdict();
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {20'h0, a};
      hwrite <= wr;
      hsize <= 3'h2;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      // idle qualifiers carry noise: the slave may act on NONSEQ or SEQ only
      hsel <= 1'($random(seed));
      haddr <= $random(seed);
      hwrite <= 1'($random(seed));
      hsize <= 3'($random(seed));
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
      chk("response", 0, hresp);
   endtask : ahb
   task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
      ahb(1'b0, a, $random(seed));
      chk(what, exp, rd);
   endtask : rdchk
   // ----------------------------------------
   // reference model
   // ----------------------------------------
   function automatic logic [31:0] exp_status(input int st);
      logic [31:0] s;
      s = '0;
      for (int a = 10; a <= 15; a++) s[a - 3] = (mr_stg[a] != mr_app[a]);
      s[6] = (mr_app[0] & 2048) != 0;
      s[5] = cfg_exp[1];
      s[4] = cfg_exp[2];
      s[3:0] = 4'(st);
      return s;
   endfunction : exp_status
   task automatic mode_set_cmd(input int a, input int d);
      u_host.send(CMD_MODE_SET, 6'(a), 12'(d));
      u_host.nops(1);
      if (!bank_active || a inside {[5:7], [16:21], [23:26]}) begin
         mr_stg[a] = d;
         if (!(a >= 10 && a <= 15 && (mr_app[0] & 2048) == 0)) mr_app[a] = d;
      end
   endtask : mode_set_cmd
   task automatic start(input logic [4:0] cfg);
      int n;
      n = 0;
      cfg_exp = cfg;
      foreach (mr_app[i]) mr_app[i] = 0;
      foreach (mr_stg[i]) mr_stg[i] = 0;
      u_host.power_up(cfg, 10);
      while (ca_training !== 1'b1 && n < 600) begin
         @(posedge clk);
         n++;
      end
      chk("training entry", 1, ca_training);
      chk("training time", 1, n < 560);
      chk("wck termination", cfg[2], wck_term_en);
      chk("ca termination", cfg[1], ca_term_en);
      chk("postpone after reset", 0, postpone_flag);
      rdchk("latched config", OFF_CFG, cfg);
      rdchk("status training", OFF_STATUS, exp_status(3));
      $display("test startup with config %h done", cfg);
   endtask : start
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      seed = 34;
      errors = 0;
      total_checks = 0;
      cycles = 0;
      reset = 1'b1;
      hsel = 1'b0;
      haddr = '0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = '0;
      bank_active = 1'b0;
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      rdchk("unmapped", 12'h0FC, 0);
      start(5'h1E);
      chk("info latency default", 14, ird_latency);
      ahb(1'b1, OFF_IRD_LAT, 32'h5);
      rdchk("info latency low", OFF_IRD_LAT, 10);
      ahb(1'b1, OFF_IRD_LAT, 32'h1F);
      rdchk("info latency high", OFF_IRD_LAT, 18);
      u_host.send(CMD_CA_TRAINING_EXIT, 6'h0, 12'h0);
      u_host.nops(2);
      u_host.send(CMD_COMMAND_START_POINT, 6'h0, 12'h0);
      u_host.nops(3);
      chk("init done", 1, init_done);
      rdchk("status ready", OFF_STATUS, exp_status(7));
      $display("test start point done");
      foreach (addrs[i]) begin
         bank_active <= 1'($random(seed));
         mode_set_cmd(addrs[i], $random(seed) & 'h7FF);
      end
      foreach (addrs[i]) rdchk("mode register", 12'(256 + 4 * addrs[i]), mr_app[addrs[i]]);
      bank_active <= 1'b1;
      mode_set_cmd(5, $random(seed) & 'h7FF);
      mode_set_cmd(3, $random(seed) & 'h7FF);
      bank_active <= 1'b0;
      rdchk("active allowed", 12'h114, mr_app[5]);
      rdchk("active blocked", 12'h10C, mr_app[3]);
      rdchk("error flags", OFF_ERR, 1);
      ahb(1'b1, OFF_ERR, 32'h3F);
      rdchk("error cleared", OFF_ERR, 0);
      $display("test mode registers done");
      mode_set_cmd(12, 'h11);
      mode_set_cmd(14, 'h22);
      mode_set_cmd(14, 'h33);
      mode_set_cmd(12, 'h44);
      rdchk("staged not applied", 12'h130, mr_app[12]);
      rdchk("status pending", OFF_STATUS, exp_status(7));
      mode_set_cmd(14, mr_app[14]);
      rdchk("status cancelled", OFF_STATUS, exp_status(7));
      u_host.send(CMD_SLEEP_ENTRY, 6'h0, 12'h0);
      for (int a = 10; a <= 15; a++) mr_app[a] = mr_stg[a];
      u_host.set_wclk(1'b0);
      u_host.nops(2);
      rdchk("status sleep", OFF_STATUS, exp_status(8));
      rdchk("applied at sleep", 12'h130, mr_app[12]);
      u_host.set_wclk(1'b1);
      u_host.nops(3);
      u_host.send(CMD_SLEEP_EXIT, 6'h0, 12'h0);
      u_host.nops(1);
      rdchk("status after sleep", OFF_STATUS, exp_status(7));
      $display("test staging done");
      mode_set_cmd(0, mr_app[0] | 'h800);
      chk("postpone set", 1, postpone_flag);
      mode_set_cmd(13, $random(seed) & 'hFFF);
      rdchk("direct apply", 12'h134, mr_app[13]);
      rdchk("status direct", OFF_STATUS, exp_status(7));
      mode_set_cmd(0, mr_app[0] & 'h7FF);
      mode_set_cmd(15, mr_app[15] ^ 1);
      u_host.set_wclk(1'b0);
      u_host.nops(3);
      rdchk("status clock lost", OFF_STATUS, exp_status(9));
      $display("test postpone and clock loss done");
      start(5'h18);
      rdchk("staged discarded", 12'h13C, 0);
      rdchk("register cleared", 12'h100, 0);
      print_verdict();
   end
endmodule : tb_sgram_init_and_mode_reg_control
`default_nettype wire
